// *** core/wit_defs.svh ***
// offsets, field positions, reset values and timing counts of the watch interval timer
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH

`define WIT_CTRL_ADDR 16'hFF41
`define WIT_CTRL_RESET 8'h00
`define WIT_BIT_SRC 3'h7
`define WIT_BIT_IVAL_HI 3'h6
`define WIT_BIT_IVAL_LO 3'h4
`define WIT_BIT_WSEL_HI 3'h3
`define WIT_BIT_WSEL_LO 3'h2
`define WIT_BIT_RUN 3'h1
`define WIT_BIT_EN 3'h0
`define WIT_MAIN_DIV 9'h100
`define WIT_IVAL_BASE 4'h4
`define WIT_CNT_TAP 11'h1FF
`define WIT_W5_TAP 11'h01F
`define WIT_W4_TAP 11'h00F
`define WIT_WSEL_14 2'h0
`define WIT_WSEL_13 2'h1
`define WIT_WSEL_5 2'h2
`define WIT_WSEL_4 2'h3

`endif

// *** core/wit_pkg.sv ***
// types shared by the watch interval timer files
`default_nettype none
package wit_pkg;
    typedef struct packed {
        logic source_clock_select;
        logic [2:0] interval_select;
        logic [1:0] watch_period_select;
        logic counter_run_control;
        logic global_run_enable;
    } wit_ctrl_s;
endpackage : wit_pkg
`default_nettype wire

// *** core/wit_tick_gen.sv ***
// watch clock enable: main clock divided by 256 or synchronised subsystem clock
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"

module wit_tick_gen #(
    parameter int DIV_W = 9
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sub_clk,
    input wire logic source_clock_select,
    output logic tick
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic main_tick;
    logic sub_s1_q;
    logic sub_s2_q;
    logic sub_s3_q;
    logic sub_tick;

    // divider for the main clock path and edge finder for the subsystem clock
    assign main_tick = (div_q == DIV_W'(`WIT_MAIN_DIV - 9'h001));
    assign div_d = main_tick ? '0 : div_q + DIV_W'(1);
    assign sub_tick = sub_s2_q & ~sub_s3_q; // rising edge, only after two flops
    assign tick = source_clock_select ? sub_tick : main_tick;

    // counter and synchroniser flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_q <= '0;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sub_s1_q <= sub_clk;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    a_main_div_gap: assert property (@(posedge clk) disable iff (!rst_b)
        main_tick |=> !main_tick [*8])
        else $error("main clock divider ticks too often");
endmodule : wit_tick_gen
`default_nettype wire

// *** core/wit_watch_interval_timer.sv ***
// watch interval timer: control register, prescaler, 5-bit counter and both interrupt pulses
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"

// What this block does
// - Reset loads the control register with zero, stopping the timer and clearing both counters.
// - The control register takes whole-byte writes and single-bit writes that change only the named bit.
// - Bit 7 picks the watch clock: zero is the main clock over 256, one is the subsystem clock.
// - Bits 6 to 4 pick the interval period of 2^4 to 2^11 watch clocks, doubling per code.
// - Bits 3 and 2 pick the watch period: 2^14, 2^13, 2^5 or 2^4 watch clocks.
// - Bit 1 low stops and clears the 5-bit counter; high lets it count.
// - Bit 0 low stops and clears prescaler and counter and silences both interrupts; the main clock divider keeps running. High enables.
// - Watch counting runs only while bits 0 and 1 are both one and clears when they are not.
// - Clearing only bit 1 restarts the watch count from zero while the prescaler keeps going.
// - The interval interrupt repeats once per chosen period while the timer is enabled.
// - The first watch interrupt of a 2^14 or 2^13 period comes one prescaler output cycle late; later ones are exact.
// - Watch and interval interrupts run together from the shared prescaler.
module wit_watch_interval_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sub_clk,
    input wire logic [15:0] addr,
    input wire logic byte_wr,
    input wire logic [7:0] wdata,
    input wire logic bit_wr,
    input wire logic [2:0] bit_idx,
    input wire logic bit_val,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic watch_period_irq,
    output logic interval_period_irq
);
    wit_pkg::wit_ctrl_s ctrl_q;
    wit_pkg::wit_ctrl_s ctrl_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [10:0] pre_q;
    logic [10:0] pre_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic armed_q;
    logic armed_d;
    logic watch_irq_q;
    logic ival_irq_q;
    logic tick;
    logic hit;
    logic running;
    logic counting;
    logic [10:0] ival_mask;
    logic ival_hit;
    logic cnt_tick;
    logic cnt_step;
    logic long_hit;
    logic short_hit;
    logic watch_hit;
    logic [7:0] bit_mask;

    // watch clock enable from the chosen source
    wit_tick_gen #(
        .DIV_W(9)
    ) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .sub_clk(sub_clk),
        .source_clock_select(ctrl_q.source_clock_select),
        .tick(tick)
    );

    // register decode: byte write or single-bit write
    assign hit = (addr == `WIT_CTRL_ADDR);
    assign bit_mask = 8'h01 << bit_idx;
    assign ctrl_d = (hit && byte_wr) ? wit_pkg::wit_ctrl_s'(wdata) :
                    (hit && bit_wr) ? wit_pkg::wit_ctrl_s'(bit_val ? (ctrl_q | bit_mask)
                                                                   : (ctrl_q & ~bit_mask)) : ctrl_q;
    assign rdata_d = (hit && rd) ? ctrl_q : 8'h00;

    // enables
    assign running = ctrl_q.global_run_enable;
    assign counting = running && ctrl_q.counter_run_control;

    // 11-bit prescaler, cleared only by the global enable
    assign pre_d = !running ? 11'h000 : (tick ? pre_q + 11'h001 : pre_q);

    // interval tap: low 4+code bits all ones on a tick
    assign ival_mask = 11'h7FF >> (3'h7 - ctrl_q.interval_select);
    assign ival_hit = running && tick && ((pre_q & ival_mask) == ival_mask);

    // 5-bit counter clocked every 2^9 watch clocks; first tap only arms it
    // the swallowed first clock is what makes the first long watch pulse one counter clock late
    assign cnt_tick = counting && tick && ((pre_q & `WIT_CNT_TAP) == `WIT_CNT_TAP);
    assign cnt_step = cnt_tick && armed_q;
    assign armed_d = !counting ? 1'b0 : (armed_q | cnt_tick);
    assign cnt_d = !counting ? 5'h00 : (cnt_step ? cnt_q + 5'h01 : cnt_q);

    // watch period select: counter overflows for long periods, prescaler taps for short
    assign long_hit = cnt_step && ((ctrl_q.watch_period_select == `WIT_WSEL_14) ? (cnt_q == 5'h1F)
                                   : (cnt_q[3:0] == 4'hF));
    assign short_hit = counting && tick &&
                       ((ctrl_q.watch_period_select == `WIT_WSEL_5) ? ((pre_q & `WIT_W5_TAP) == `WIT_W5_TAP)
                                                                     : ((pre_q & `WIT_W4_TAP) == `WIT_W4_TAP));
    assign watch_hit = ctrl_q.watch_period_select[1] ? short_hit : long_hit;

    // state flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= wit_pkg::wit_ctrl_s'(`WIT_CTRL_RESET);
            rdata_q <= 8'h00;
            pre_q <= 11'h000;
            cnt_q <= 5'h00;
            armed_q <= 1'b0;
            watch_irq_q <= 1'b0;
            ival_irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            armed_q <= armed_d;
            watch_irq_q <= watch_hit;
            ival_irq_q <= ival_hit;
        end
    end

    assign rdata = rdata_q;
    assign watch_period_irq = watch_irq_q;
    assign interval_period_irq = ival_irq_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // first cycle out of reset: register, counters and outputs all at rest
    a_reset_clears_ctrl: assert property ($rose(rst_b) |-> ctrl_q == 8'h00 && rdata == 8'h00 &&
        pre_q == 11'h000 && cnt_q == 5'h00 && !watch_period_irq && !interval_period_irq)
        else $error("control register not zero after reset");

    // a single-bit write changes the named bit and nothing else
    a_bit_write_only: assert property (hit && bit_wr && !byte_wr |=>
        ((ctrl_q ^ $past(ctrl_q)) & ~$past(bit_mask)) == 8'h00 && ctrl_q[$past(bit_idx)] == $past(bit_val))
        else $error("single-bit write touched other bits");

    // a whole-byte write lands as written
    a_byte_write_lands: assert property (hit && byte_wr |=> ctrl_q == $past(wdata))
        else $error("byte write did not land");

    // without a write strobe at our address the control byte holds
    a_ctrl_holds: assert property (!(hit && (byte_wr || bit_wr)) |=> ctrl_q == $past(ctrl_q))
        else $error("control register changed without a write");

    // a read at our address returns the control byte one cycle later
    a_read_returns: assert property (hit && rd |=> rdata == $past(ctrl_q))
        else $error("read data differs from control register");

    // read data rests at zero between reads and for other addresses
    a_read_idle: assert property (!(hit && rd) |=> rdata == 8'h00)
        else $error("read data not zero without a read");

    // the global enable low clears the prescaler
    a_prescaler_clear: assert property (!running |=> pre_q == 11'h000)
        else $error("prescaler not cleared while disabled");

    // the prescaler steps once per watch clock while enabled
    a_prescaler_step: assert property (running && tick |=> pre_q == $past(pre_q) + 11'h001)
        else $error("prescaler missed a watch clock");

    // and stands still between watch clocks
    a_prescaler_hold: assert property (running && !tick |=> pre_q == $past(pre_q))
        else $error("prescaler moved without a watch clock");

    // the counter enable low clears the counter and its arming
    a_counter_clear: assert property (!counting |=> cnt_q == 5'h00 && !armed_q)
        else $error("counter not cleared while stopped");

    // the 5-bit counter steps only on an armed counter clock
    a_counter_step: assert property (cnt_step |=> cnt_q == $past(cnt_q) + 5'h01)
        else $error("counter missed a step");

    a_counter_hold: assert property (counting && !cnt_step |=> cnt_q == $past(cnt_q))
        else $error("counter moved between steps");

    // stopping only the counter leaves the prescaler phase alone
    a_restart_keeps_pre: assert property (running && !counting && !tick |=> pre_q == $past(pre_q))
        else $error("prescaler disturbed by counter stop");

    // an interval pulse lands just after the chosen prescaler bits roll over
    a_interval_period: assert property (interval_period_irq |->
        $past(running) && ((pre_q & $past(ival_mask)) == 11'h000))
        else $error("interval pulse off its period");

    // every interval tap while enabled gives a pulse
    a_interval_fires: assert property (running && tick && (pre_q & ival_mask) == ival_mask |=>
        interval_period_irq)
        else $error("interval tap without a pulse");

    // a watch pulse needs both enables
    a_watch_needs_run: assert property (watch_period_irq |-> $past(counting))
        else $error("watch pulse while counter stopped");

    // a long watch pulse follows the counter wrap of the chosen length
    a_long_watch_wrap: assert property (watch_period_irq && !$past(ctrl_q.watch_period_select[1]) |->
        $past(cnt_step) && ($past(ctrl_q.watch_period_select[0]) ? cnt_q[3:0] == 4'h0 : cnt_q == 5'h00))
        else $error("long watch pulse off the counter wrap");

    // a short watch pulse follows the prescaler tap of the chosen length
    a_short_watch_tap: assert property (watch_period_irq && $past(ctrl_q.watch_period_select[1]) |->
        (pre_q & ($past(ctrl_q.watch_period_select[0]) ? `WIT_W4_TAP : `WIT_W5_TAP)) == 11'h000)
        else $error("short watch pulse off the prescaler tap");

    // nothing pulses while the timer is stopped
    a_stop_silences: assert property (!running |=> !interval_period_irq && !watch_period_irq)
        else $error("interrupt pulse while stopped");

    // both request lines are single-cycle pulses
    a_irq_one_cycle: assert property ((watch_period_irq || interval_period_irq) |=>
        !watch_period_irq && !interval_period_irq)
        else $error("interrupt pulse longer than one cycle");

    // the first counter clock after start only arms, it does not count
    a_first_arm: assert property (cnt_tick && !armed_q |=> cnt_q == 5'h00)
        else $error("counter started without the one-cycle delay");

    // once armed the counter stays armed while it may count
    a_armed_hold: assert property (armed_q && counting |=> armed_q)
        else $error("counter lost its arming while counting");
endmodule : wit_watch_interval_timer
`default_nettype wire

// *** verif/wit_watch_interval_timer_bench.sv ***
// self-checking bench for the watch interval timer: register access and interrupt spacing
`timescale 1ns/1ns
`default_nettype none
`include "wit_defs.svh"

module wit_watch_interval_timer_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sub_clk = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic byte_wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic bit_wr = 1'b0;
    logic [2:0] bit_idx = 3'h0;
    logic bit_val = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic watch_period_irq;
    logic interval_period_irq;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    int nw;
    int ni;
    logic [7:0] d;
    wit_pkg::wit_ctrl_s c;

    // main clock 100 MHz; subsystem clock gives one watch tick per 2 main cycles
    always #5 clk = ~clk;
    always #10 sub_clk = ~sub_clk;

    wit_watch_interval_timer dut_u (.clk(clk), .rst_b(rst_b), .sub_clk(sub_clk), .addr(addr),
        .byte_wr(byte_wr), .wdata(wdata), .bit_wr(bit_wr), .bit_idx(bit_idx), .bit_val(bit_val),
        .rd(rd), .rdata(rdata), .watch_period_irq(watch_period_irq),
        .interval_period_irq(interval_period_irq));

    // hang guard: tests need about 60000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic wr_byte(input logic [7:0] v);
        @(posedge clk);
        addr <= `WIT_CTRL_ADDR;
        byte_wr <= 1'b1;
        wdata <= v;
        @(posedge clk);
        byte_wr <= 1'b0;
    endtask : wr_byte

    task automatic wr_bit(input logic [2:0] i, input logic v);
        @(posedge clk);
        addr <= `WIT_CTRL_ADDR;
        bit_wr <= 1'b1;
        bit_idx <= i;
        bit_val <= v;
        @(posedge clk);
        bit_wr <= 1'b0;
    endtask : wr_bit

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    function automatic logic pick(input logic w);
        return w ? watch_period_irq : interval_period_irq;
    endfunction : pick

    // waits for a pulse, checks it lasts one cycle, returns cycles to the next one
    task automatic spacing(input logic w, output int gap);
        do begin @(posedge clk); #1; end while (pick(w) !== 1'b1);
        @(posedge clk);
        #1 gap = 1;
        check("pulse width", 32'h0, {31'h0, pick(w)});
        while (pick(w) !== 1'b1) begin @(posedge clk); #1 gap++; end
    endtask : spacing

    // counts cycles from now until the chosen line pulses
    task automatic wait_pulse(input logic w, output int gap);
        gap = 0;
        do begin @(posedge clk); #1 gap++; end while (pick(w) !== 1'b1);
    endtask : wait_pulse

    // counts pulses on both lines over a number of cycles
    task automatic count(input int cycles);
        nw = 0;
        ni = 0;
        repeat (cycles) begin @(posedge clk); #1 nw += watch_period_irq; ni += interval_period_irq; end
    endtask : count

    // main sequence: register access, then each interval period and the 2^4, 2^5 and 2^13 watch periods
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(`WIT_CTRL_ADDR, d);
        check("reset value", 32'h0, {24'h0, d});
        wr_byte(8'hA4);
        rd_reg(`WIT_CTRL_ADDR, d);
        check("byte write", 32'hA4, {24'h0, d});
        wr_bit(3'h5, 1'b0);
        wr_bit(3'h1, 1'b1);
        rd_reg(`WIT_CTRL_ADDR, d);
        check("bit write", 32'h86, {24'h0, d});
        rd_reg(16'hFF42, d);
        check("unmapped read", 32'h0, {24'h0, d});
        count(300);
        check("stopped pulses", 32'h0, 32'(nw + ni));
        for (int i = 0; i < 8; i++) begin
            wr_byte(8'h00); // stop before touching bits 7 to 2
            c = '{1'b1, 3'(i), 2'h0, 1'b0, 1'b1};
            wr_byte(c);
            spacing(1'b0, n);
            check("interval gap", 32'(32 << i), 32'(n));
        end
        wr_byte(8'h00);
        wr_byte(8'h8D);
        count(400);
        check("watch held", 32'h0, 32'(nw));
        check("interval alone", 32'h1, {31'h0, ni > 5});
        wr_bit(3'h1, 1'b1);
        spacing(1'b1, n);
        check("watch gap 4", 32'd32, 32'(n));
        spacing(1'b0, n);
        check("interval beside watch", 32'd32, 32'(n));
        wr_byte(8'h00);
        wr_byte(8'h8B);
        spacing(1'b1, n);
        check("watch gap 5", 32'd64, 32'(n));
        spacing(1'b0, n);
        check("interval gap 16", 32'd32, 32'(n));
        // stop the counter right after an interval pulse; the next one keeps the old phase
        wr_bit(3'h1, 1'b0);
        wait_pulse(1'b0, n);
        check("prescaler phase", 32'd30, 32'(n));
        count(300);
        check("watch cleared", 32'h0, 32'(nw));
        check("prescaler kept", 32'h1, {31'h0, ni > 3});
        // long period: first pulse after 2^13 + 2^9 ticks of 2 cycles, less up to one cycle of tick phase
        wr_byte(8'h00);
        wr_byte(8'h87);
        wait_pulse(1'b1, n);
        check("first watch late", 32'h1, {31'h0, n >= 17407 && n <= 17408});
        wait_pulse(1'b1, n);
        check("watch gap 13", 32'd16384, 32'(n));
        wr_byte(8'h00);
        wr_byte(8'h01);
        spacing(1'b0, n);
        check("main clock gap", 32'd4096, 32'(n));
        test_done();
    end
endmodule : wit_watch_interval_timer_bench
`default_nettype wire
